// ==== shared/eoc_defs.svh ====
// constants for the operations channel message handler
`ifndef EOC_DEFS_SVH
`define EOC_DEFS_SVH
`define EOC_ADDR_OWN 3'h0
`define EOC_ADDR_BCAST 3'h7
`define EOC_IND_MSG 1'h1
`define EOC_CODE_LOOP_ALL 8'h50
`define EOC_CODE_LOOP_B1 8'h51
`define EOC_CODE_LOOP_B2 8'h52
`define EOC_CODE_REQ_CRC 8'h53
`define EOC_CODE_NOTE_CRC 8'h54
`define EOC_CODE_NORMAL 8'hff
`define EOC_CODE_HOLD 8'h00
`define EOC_CODE_UTC 8'haa
`define EOC_REPEAT_NEEDED 2'h3
`define EOC_FRAME_IDLE 12'h0ff
`endif

// ==== shared/eoc_pkg.sv ====
// types for the operations channel message handler
package eoc_pkg;
    typedef struct packed {
        logic [2:0] addr;
        logic ind;
        logic [7:0] code;
    } eoc_frame_t;
    typedef enum logic [1:0] {
        ST_NORMAL = 2'b00,
        ST_COUNT = 2'b01,
        ST_ACTED = 2'b10
    } proc_state_t;
endpackage

// ==== shared/eoc_if.sv ====
// link between line termination and network termination
`timescale 1ns/100ps
interface eoc_if;
    import eoc_pkg::*;
    eoc_frame_t down_frame;
    logic down_valid;
    eoc_frame_t up_frame;
    logic up_valid;
    logic xcvr_reset;
    modport network_termination (
        input down_frame,
        input down_valid,
        input xcvr_reset,
        output up_frame,
        output up_valid
    );
    modport line_termination (
        output down_frame,
        output down_valid,
        output xcvr_reset,
        input up_frame,
        input up_valid
    );
endinterface

// ==== src/eoc_repeat_counter.sv ====
// counter of identical consecutive frames, saturating at three
`timescale 1ns/100ps
`include "eoc_defs.svh"
module eoc_repeat_counter
    import eoc_pkg::*;
(
    input wire logic i_mclk,
    input wire logic i_rst,
    input wire logic i_clear,
    input wire logic i_strobe,
    input wire eoc_frame_t i_frame,
    output logic o_third
);
    eoc_frame_t last_ff;
    eoc_frame_t nxt_last;
    logic [1:0] cnt_ff;
    logic [1:0] nxt_cnt;

    // same frame counts up, a different one restarts at one
    always_comb
    begin
        nxt_last = last_ff;
        nxt_cnt = cnt_ff;
        if (i_clear)
        begin
            nxt_cnt = 2'h0;
        end
        else if (i_strobe)
        begin
            nxt_last = i_frame;
            if (cnt_ff != 2'h0 && i_frame == last_ff)
            begin
                nxt_cnt = (cnt_ff == `EOC_REPEAT_NEEDED) ? cnt_ff : cnt_ff + 2'h1;
            end
            else
            begin
                nxt_cnt = 2'h1;
            end
        end
    end

    always_ff @(posedge i_mclk or posedge i_rst)
    begin
        if (i_rst)
        begin
            last_ff <= '0;
            cnt_ff <= 2'h0;
        end
        else
        begin
            last_ff <= nxt_last;
            cnt_ff <= nxt_cnt;
        end
    end

    // combinational on purpose: true in the strobe cycle of third receipt or later
    assign o_third = i_strobe && !i_clear && (nxt_cnt == `EOC_REPEAT_NEEDED);
endmodule

// ==== src/eoc_nt_handler.sv ====
// network termination end: decodes, latches and answers operations frames
`timescale 1ns/100ps
`include "eoc_defs.svh"
module eoc_nt_handler
    import eoc_pkg::*;
#(
    parameter bit HAS_B_LOOP = 1'b1
)
(
    input wire logic i_mclk,
    input wire logic i_rst,
    eoc_if.network_termination link,
    input wire logic i_te_active,
    output logic o_loop_all,
    output logic o_loop_b1,
    output logic o_loop_b2,
    output logic o_send_bad_crc,
    output logic o_bad_crc_notice,
    output logic o_activation_indicator_bit,
    output proc_state_t o_state
);
    // decoded view of the incoming frame, latches and the reply register
    eoc_frame_t rx;
    logic addr_ok;
    logic known;
    logic third;
    logic loop_all_ff, loop_b1_ff, loop_b2_ff, req_crc_ff, note_crc_ff;
    logic nxt_loop_all, nxt_loop_b1, nxt_loop_b2, nxt_req_crc, nxt_note_crc;
    proc_state_t state_ff;
    proc_state_t nxt_state;
    eoc_frame_t up_ff;
    eoc_frame_t nxt_up;
    logic up_valid_ff;
    logic act_ff;
    logic nxt_up_valid;
    logic nxt_act;

    assign rx = link.down_frame;
    // foreign addresses never reach the counter
    assign addr_ok = (rx.addr == `EOC_ADDR_OWN) || (rx.addr == `EOC_ADDR_BCAST);

    // recognised menu; reserved and future codes fall out as unsupported
    always_comb
    begin
        known = 1'b0;
        if (rx.ind == `EOC_IND_MSG)
        begin
            case (rx.code)
                `EOC_CODE_LOOP_ALL, `EOC_CODE_REQ_CRC, `EOC_CODE_NOTE_CRC,
                `EOC_CODE_NORMAL, `EOC_CODE_HOLD: known = 1'b1;
                `EOC_CODE_LOOP_B1, `EOC_CODE_LOOP_B2: known = HAS_B_LOOP;
                default: known = 1'b0;
            endcase
        end
    end

    // foreign frames never strobe the counter; transceiver reset clears it
    eoc_repeat_counter u_repeat (
        .i_mclk(i_mclk),
        .i_rst(i_rst),
        .i_clear(link.xcvr_reset),
        .i_strobe(link.down_valid && addr_ok),
        .i_frame(rx),
        .o_third(third)
    );

    // latched actions and processor state
    // transceiver reset beats a frame in the same cycle, so no action survives it
    always_comb
    begin
        nxt_loop_all = loop_all_ff;
        nxt_loop_b1 = loop_b1_ff;
        nxt_loop_b2 = loop_b2_ff;
        nxt_req_crc = req_crc_ff;
        nxt_note_crc = note_crc_ff;
        nxt_state = state_ff;
        if (link.xcvr_reset)
        begin
            nxt_loop_all = 1'b0;
            nxt_loop_b1 = 1'b0;
            nxt_loop_b2 = 1'b0;
            nxt_req_crc = 1'b0;
            nxt_note_crc = 1'b0;
            nxt_state = ST_NORMAL;
        end
        else if (link.down_valid && addr_ok)
        begin
            if (!third)
            begin
                nxt_state = ST_COUNT;
            end
            else if (known)
            begin
                nxt_state = ST_ACTED;
                case (rx.code)
                    `EOC_CODE_LOOP_ALL: nxt_loop_all = 1'b1;
                    `EOC_CODE_LOOP_B1: nxt_loop_b1 = 1'b1;
                    `EOC_CODE_LOOP_B2: nxt_loop_b2 = 1'b1;
                    `EOC_CODE_REQ_CRC: nxt_req_crc = 1'b1;
                    `EOC_CODE_NOTE_CRC: nxt_note_crc = 1'b1;
                    `EOC_CODE_NORMAL:
                    begin
                        nxt_loop_all = 1'b0;
                        nxt_loop_b1 = 1'b0;
                        nxt_loop_b2 = 1'b0;
                        nxt_req_crc = 1'b0;
                        nxt_note_crc = 1'b0;
                        nxt_state = ST_NORMAL;
                    end
                    `EOC_CODE_HOLD: nxt_state = state_ff;
                    default: nxt_state = state_ff;
                endcase
            end
        end
    end

    // reply chosen per frame; echo unless foreign or unsupported on third
    always_comb
    begin
        nxt_up = up_ff;
        if (link.down_valid && !link.xcvr_reset)
        begin
            if (!addr_ok)
            begin
                nxt_up = '{addr: `EOC_ADDR_OWN, ind: `EOC_IND_MSG, code: `EOC_CODE_HOLD};
            end
            else if (third && !known)
            begin
                nxt_up = '{addr: `EOC_ADDR_OWN, ind: `EOC_IND_MSG, code: `EOC_CODE_UTC};
            end
            else
            begin
                nxt_up = rx;
            end
        end
    end

    // reply strobe and activation bit; only full loopback forces the bit,
    // so a single B loopback leaves it to the terminal status
    always_comb
    begin
        nxt_up_valid = link.down_valid && !link.xcvr_reset;
        nxt_act = i_te_active || loop_all_ff;
    end

    // every register of the handler; reset gives an idle reply frame
    always_ff @(posedge i_mclk or posedge i_rst)
    begin
        if (i_rst)
        begin
            loop_all_ff <= 1'b0;
            loop_b1_ff <= 1'b0;
            loop_b2_ff <= 1'b0;
            req_crc_ff <= 1'b0;
            note_crc_ff <= 1'b0;
            state_ff <= ST_NORMAL;
            up_ff <= `EOC_FRAME_IDLE;
            up_valid_ff <= 1'b0;
            act_ff <= 1'b0;
        end
        else
        begin
            loop_all_ff <= nxt_loop_all;
            loop_b1_ff <= nxt_loop_b1;
            loop_b2_ff <= nxt_loop_b2;
            req_crc_ff <= nxt_req_crc;
            note_crc_ff <= nxt_note_crc;
            state_ff <= nxt_state;
            up_ff <= nxt_up;
            up_valid_ff <= nxt_up_valid;
            act_ff <= nxt_act;
        end
    end

    // all outputs straight from flip-flops
    assign link.up_frame = up_ff;
    assign link.up_valid = up_valid_ff;
    assign o_loop_all = loop_all_ff;
    assign o_loop_b1 = loop_b1_ff;
    assign o_loop_b2 = loop_b2_ff;
    assign o_send_bad_crc = req_crc_ff;
    assign o_bad_crc_notice = note_crc_ff;
    assign o_activation_indicator_bit = act_ff;
    assign o_state = state_ff;
endmodule

// ==== src/eoc_lt_sender.sv ====
// line termination end: sends the command once per tick and flags three matching echoes
`timescale 1ns/100ps
`include "eoc_defs.svh"
module eoc_lt_sender
    import eoc_pkg::*;
(
    input wire logic i_mclk,
    input wire logic i_rst,
    eoc_if.line_termination link,
    input wire logic i_frame_tick,
    input wire logic i_cmd_load,
    input wire eoc_frame_t i_cmd,
    input wire logic i_xcvr_reset,
    output logic o_confirmed,
    output logic o_refused,
    output eoc_frame_t o_last_reply
);
    eoc_frame_t cmd_ff;
    eoc_frame_t nxt_cmd;
    logic [1:0] match_ff, nxt_match;
    logic [1:0] utc_ff, nxt_utc;
    eoc_frame_t reply_ff;
    eoc_frame_t nxt_reply;
    logic valid_ff;

    // new command resets the tallies; matching echo counts toward three
    always_comb
    begin
        nxt_cmd = cmd_ff;
        nxt_reply = reply_ff;
        nxt_match = match_ff;
        nxt_utc = utc_ff;
        if (link.up_valid)
        begin
            nxt_reply = link.up_frame;
        end
        if (i_cmd_load)
        begin
            nxt_cmd = i_cmd;
            nxt_match = 2'h0;
            nxt_utc = 2'h0;
        end
        else if (link.up_valid)
        begin
            nxt_match = (link.up_frame == cmd_ff) ?
                ((match_ff == `EOC_REPEAT_NEEDED) ? match_ff : match_ff + 2'h1) : 2'h0;
            nxt_utc = (link.up_frame.code == `EOC_CODE_UTC) ?
                ((utc_ff == `EOC_REPEAT_NEEDED) ? utc_ff : utc_ff + 2'h1) : 2'h0;
        end
    end

    always_ff @(posedge i_mclk or posedge i_rst)
    begin
        if (i_rst)
        begin
            cmd_ff <= '{addr: `EOC_ADDR_OWN, ind: `EOC_IND_MSG, code: `EOC_CODE_HOLD};
            match_ff <= 2'h0;
            utc_ff <= 2'h0;
            reply_ff <= `EOC_FRAME_IDLE;
            valid_ff <= 1'b0;
        end
        else
        begin
            cmd_ff <= nxt_cmd;
            match_ff <= nxt_match;
            utc_ff <= nxt_utc;
            reply_ff <= nxt_reply;
            // the command is sent continuously, one frame per tick
            valid_ff <= i_frame_tick;
        end
    end

    assign link.down_frame = cmd_ff;
    assign link.down_valid = valid_ff;
    assign link.xcvr_reset = i_xcvr_reset;
    assign o_confirmed = (match_ff == `EOC_REPEAT_NEEDED);
    assign o_refused = (utc_ff == `EOC_REPEAT_NEEDED);
    assign o_last_reply = reply_ff;
endmodule

// ==== tb/eoc_link_chk.sv ====
// link checker for the operations channel exchange
`timescale 1ns/100ps
module eoc_link_chk
    import eoc_pkg::*;
(
    input wire logic i_mclk,
    input wire logic i_rst,
    input wire eoc_frame_t down_frame,
    input wire logic down_valid,
    input wire eoc_frame_t up_frame,
    input wire logic up_valid,
    input wire logic xcvr_reset
);
    logic take;
    logic same;
    logic rep3;
    logic known;
    eoc_frame_t prev_ff;
    eoc_frame_t nxt_prev;
    logic [1:0] cnt_ff;
    logic [1:0] nxt_cnt;
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_rst);
    // repeat count of addressed frames; foreign frames must not restart it
    always_comb
    begin
        take = down_valid && !xcvr_reset && (down_frame.addr inside {3'h0, 3'h7});
        same = (cnt_ff != 2'h0) && (down_frame == prev_ff);
        rep3 = same && (cnt_ff >= 2'h2);
        known = down_frame.ind && (down_frame.code inside {8'h00, [8'h50:8'h54], 8'hff});
        nxt_prev = take ? down_frame : prev_ff;
        nxt_cnt = cnt_ff;
        if (xcvr_reset)
            nxt_cnt = 2'h0;
        else if (take)
            nxt_cnt = !same ? 2'h1 : ((cnt_ff == 2'h3) ? 2'h3 : cnt_ff + 2'h1);
    end
    // registers of the repeat tracker
    always_ff @(posedge i_mclk or posedge i_rst)
    begin
        if (i_rst)
        begin
            prev_ff <= 12'h000;
            cnt_ff <= 2'h0;
        end
        else
        begin
            prev_ff <= nxt_prev;
            cnt_ff <= nxt_cnt;
        end
    end
    property p_reply;
        down_valid && !xcvr_reset |=> up_valid;
    endproperty
    a_reply: assert property (p_reply) else $error("no reply after a frame");
    property p_quiet;
        !(down_valid && !xcvr_reset) |=> !up_valid;
    endproperty
    a_quiet: assert property (p_quiet) else $error("reply without a taken frame");
    property p_foreign;
        down_valid && !xcvr_reset && !(down_frame.addr inside {3'h0, 3'h7})
            |=> up_frame == 12'h100;
    endproperty
    a_foreign: assert property (p_foreign) else $error("foreign frame not held");
    property p_echo;
        take && !rep3 |=> up_frame == $past(down_frame);
    endproperty
    a_echo: assert property (p_echo) else $error("early receipt not echoed");
    property p_known;
        take && rep3 && known |=> up_frame == $past(down_frame);
    endproperty
    a_known: assert property (p_known) else $error("known message not echoed");
    property p_unable;
        take && rep3 && !known |=> up_frame.ind && up_frame.code == 8'haa;
    endproperty
    a_unable: assert property (p_unable) else $error("no unable reply");
    property p_unable_addr;
        take && rep3 && !known |=> up_frame.addr == 3'h0;
    endproperty
    a_unable_addr: assert property (p_unable_addr) else $error("unable reply addr");
    property p_stands;
        !up_valid |-> $stable(up_frame);
    endproperty
    a_stands: assert property (p_stands) else $error("reply frame moved");
endmodule

// ==== tb/operations_channel_message_handler_tb_top.sv ====
// bench for the operations channel exchange between both ends
`timescale 1ns/100ps
module operations_channel_message_handler_tb_top;
    import eoc_pkg::*;
    localparam int DLY = 10;
    logic i_mclk;
    logic i_rst;
    logic frame_tick;
    logic cmd_load;
    logic xcvr_in;
    logic te_active;
    logic confirmed;
    eoc_frame_t cmd;
    wire [7:0] flags;
    logic refused;
    eoc_frame_t last_reply;
    proc_state_t state;
    int fail_count;
    int checks_done;
    logic [11:0] bad [6] = '{12'h140, 12'hf2a, 12'h16f, 12'h19c, 12'h1a0, 12'h050};
    eoc_if link ();
    eoc_lt_sender i_eoc_lt_sender (.i_mclk(i_mclk), .i_rst(i_rst), .link(link),
        .i_frame_tick(frame_tick), .i_cmd_load(cmd_load), .i_cmd(cmd),
        .i_xcvr_reset(xcvr_in), .o_confirmed(confirmed), .o_refused(refused),
        .o_last_reply(last_reply));
    eoc_nt_handler i_eoc_nt_handler (.i_mclk(i_mclk), .i_rst(i_rst), .link(link),
        .i_te_active(te_active), .o_loop_all(flags[7]), .o_loop_b1(flags[6]),
        .o_loop_b2(flags[5]), .o_send_bad_crc(flags[4]), .o_bad_crc_notice(flags[3]),
        .o_activation_indicator_bit(flags[2]), .o_state(state));
    assign flags[1:0] = state;
    eoc_link_chk i_eoc_link_chk (.i_mclk(i_mclk), .i_rst(i_rst),
        .down_frame(link.down_frame), .down_valid(link.down_valid),
        .up_frame(link.up_frame), .up_valid(link.up_valid), .xcvr_reset(link.xcvr_reset));
    // 10 MHz clock
    initial
    begin
        i_mclk = 1'b0;
        forever #50 i_mclk = ~i_mclk;
    end
    task automatic results;
        $display("checks_done=%0d fail_count=%0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic chk_frame(input logic [11:0] got, input logic [11:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            fail_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // flags: loop_all b1 b2 crc notice act state[1:0]; mask hides unsettled bits
    task automatic chk_flags(input logic [7:0] exp, input logic [7:0] mask);
        checks_done++;
        if ((flags & mask) !== exp)
        begin
            fail_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, flags & mask, exp);
        end
    endtask
    // first two replies must be e1, later ones e3
    task automatic send(input logic [11:0] f, input int n, input logic [11:0] e1,
        input logic [11:0] e3);
        int w;
        @(posedge i_mclk);
        #DLY cmd = f;
        cmd_load = 1'b1;
        @(posedge i_mclk);
        #DLY cmd_load = 1'b0;
        for (int k = 0; k < n; k++)
        begin
            frame_tick = 1'b1;
            @(posedge i_mclk);
            #DLY frame_tick = 1'b0;
            w = 0;
            while (link.up_valid !== 1'b1 && w < 8)
            begin
                @(posedge i_mclk);
                #DLY w++;
            end
            chk_frame(link.down_frame, f);
            chk_frame(link.up_frame, (k < 2) ? e1 : e3);
        end
        repeat (2) @(posedge i_mclk);
        #DLY;
    endtask
    // watchdog: whole run needs well under 1500 cycles
    initial
    begin
        repeat (4000) @(posedge i_mclk);
        fail_count++;
        results();
    end
    initial
    begin
        fail_count = 0;
        checks_done = 0;
        i_rst = 1'b1;
        cmd = 12'h100;
        cmd_load = 1'b0;
        frame_tick = 1'b0;
        xcvr_in = 1'b0;
        te_active = 1'b0;
        repeat (8) @(posedge i_mclk);
        #DLY i_rst = 1'b0;
        chk_frame(link.up_frame, 12'h0ff);
        chk_flags(8'h00, 8'hff);
        send(12'h351, 3, 12'h100, 12'h100);
        chk_frame(last_reply, 12'h100);
        chk_flags(8'h00, 8'hff);
        send(12'hf51, 3, 12'hf51, 12'hf51);
        chk_flags(8'h42, 8'hff);
        te_active = 1'b1;
        repeat (2) @(posedge i_mclk);
        #DLY chk_flags(8'h46, 8'hff);
        send(12'h152, 2, 12'h152, 12'h152);
        chk_flags(8'h45, 8'hff);
        send(12'h152, 1, 12'h152, 12'h152);
        chk_flags(8'h66, 8'hff);
        te_active = 1'b0;
        send(12'h150, 3, 12'h150, 12'h150);
        chk_flags(8'he6, 8'hff);
        send(12'h153, 3, 12'h153, 12'h153);
        send(12'hf54, 3, 12'hf54, 12'hf54);
        chk_flags(8'hfe, 8'hff);
        foreach (bad[i])
        begin
            send(bad[i], 5, bad[i], 12'h1aa);
            chk_frame({11'h000, refused}, 12'h001);
            chk_frame(last_reply, 12'h1aa);
        end
        chk_flags(8'hfc, 8'hfc);
        send(12'h100, 3, 12'h100, 12'h100);
        chk_flags(8'hfc, 8'hfc);
        send(12'h1ff, 3, 12'h1ff, 12'h1ff);
        chk_flags(8'h00, 8'hff);
        send(12'h150, 3, 12'h150, 12'h150);
        chk_frame({11'h000, confirmed}, 12'h001);
        xcvr_in = 1'b1;
        frame_tick = 1'b1;
        @(posedge i_mclk);
        #DLY frame_tick = 1'b0;
        repeat (3) @(posedge i_mclk);
        #DLY xcvr_in = 1'b0;
        repeat (2) @(posedge i_mclk);
        #DLY chk_flags(8'h00, 8'hff);
        send(12'h150, 2, 12'h150, 12'h150);
        chk_flags(8'h00, 8'hfc);
        results();
    end
endmodule
